// [lpm_polling_pkg.sv]
// constants and frame layout for the low-power polling configuration block
// assumes a 125 MHz core clock and a 32-bit spi frame from the host
package lpm_polling_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int DEBOUNCE_EXTRA_NS = 1200000;
	// least time: round up
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_POLL_DIVIDE = 4;

	localparam int GROUND_CHANNELS = 14;
	localparam int PROG_CHANNELS = 8;
	localparam int FRAME_BITS = 32;

	localparam logic [6:0] ADDR_SLOW_POLL_GROUND = 7'h19;
	localparam logic [6:0] ADDR_DEBOUNCE_PROG = 7'h1A;
	localparam logic [6:0] ADDR_DEBOUNCE_GROUND = 7'h1B;
	localparam logic [6:0] ADDR_ENTER_SLEEP = 7'h1C;

	localparam logic [13:0] SLOW_POLL_GROUND_RESET = 14'h0000;
	localparam logic [7:0] DEBOUNCE_PROG_RESET = 8'h00;
	localparam logic [13:0] DEBOUNCE_GROUND_RESET = 14'h0000;
	localparam logic [23:0] ENTER_SLEEP_DATA = 24'h000000;

	localparam int RET_FAULT_BIT = 23;
	localparam int RET_INT_BIT = 22;

	typedef struct packed {
		logic [6:0] addr;
		logic write;
		logic [23:0] data;
	} frame_type;

	typedef struct packed {
		logic [7:0] unused;
		logic fault;
		logic intflag;
		logic [21:0] data;
	} answer_type;

endpackage : lpm_polling_pkg

// [lpm_polling_config.sv]
// spi-reached configuration of low-power polling and wake-up debounce
// assumes spi mode 0 from the host, sclk well below clk/4, pins asynchronous
`timescale 1ns/100ps

// Notes on behaviour
// - a slow-polling bit of 1 polls that input at one quarter of the normal rate, 0 at the normal rate.
// - the ground slow-polling register at 0x19 is read/write, bits 0..13, others unused, clear at power-up.
// - with a debounce bit of 0 the state change is judged by voltage difference.
// - with a debounce bit of 1 the polling current stays on 1.2 ms in all, one clock short of 1.2 ms longer, and the final level is judged.
// - the programmable debounce register at 0x1A is read/write, bits 0..7, clear at power-up.
// - the ground debounce register at 0x1B is read/write, bits 0..13, clear at power-up.
// - low-power mode is entered only by the dedicated command, by nothing else.
// - every register keeps its value across a stay in low-power mode.
// - the sleep register is write-only and writing it with data 0 starts low-power polling at once.
// - the first frame after leaving low-power mode returns both flags at 1 and the input pin states.
// - a frame is address in bits 31..25, write flag in bit 24 and data in bits 23..0.
// - pending fault and interrupt show in bits 23 and 22 of the return word.
module lpm_polling_config #(
	parameter int DEBOUNCE_COUNT = lpm_polling_pkg::DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// spi pins from the host
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic mosi,
	output logic miso,
	// pins and core status
	input wire logic wake_request,
	input wire logic [21:0] switch_state,
	input wire logic fault_pending,
	input wire logic int_pending,
	input wire logic poll_tick,
	// low-power polling outputs, ground channels low, programmable high
	output logic low_power_mode,
	output logic [21:0] poll_current_on,
	output logic [21:0] sample_strobe,
	output logic [21:0] sample_by_level
);
	localparam int CH = lpm_polling_pkg::GROUND_CHANNELS + lpm_polling_pkg::PROG_CHANNELS;
	localparam int GC = lpm_polling_pkg::GROUND_CHANNELS;
	localparam int EXT_W = $clog2(DEBOUNCE_COUNT + 1);
	localparam logic [EXT_W-1:0] EXT_LOAD = EXT_W'(DEBOUNCE_COUNT - 1);

	logic sclk_s1, sclk_s2, sclk_s3;
	logic cs_s1, cs_s2, cs_s3;
	logic mosi_s1, mosi_s2;
	logic wake_s1, wake_s2;
	logic [21:0] sw_s1, sw_s2;
	logic [31:0] rx_shift;
	logic [31:0] tx_shift;
	logic [5:0] bit_count;
	logic [21:0] read_data;
	logic wake_report;
	logic [13:0] slow_poll_ground_channels;
	logic [7:0] debounce_programmable_channels;
	logic [13:0] debounce_ground_channels;
	lpm_polling_pkg::frame_type frame;
	lpm_polling_pkg::answer_type next_answer;
	logic sclk_rise, sclk_fall, frame_start, frame_end, frame_ok, enter_cmd;
	logic [CH-1:0] slow_bit, deb_bit, poll_now;

	// two flops on every pin before use
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
			sw_s1 <= 22'h000000;
			sw_s2 <= 22'h000000;
		end
		else
		begin
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1 <= cs_b;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			mosi_s1 <= mosi;
			mosi_s2 <= mosi_s1;
			wake_s1 <= wake_request;
			wake_s2 <= wake_s1;
			sw_s1 <= switch_state;
			sw_s2 <= sw_s1;
		end
	end

	assign sclk_rise = !cs_s2 && sclk_s2 && !sclk_s3;
	assign sclk_fall = !cs_s2 && !sclk_s2 && sclk_s3;
	assign frame_start = !cs_s2 && cs_s3;
	assign frame_end = cs_s2 && !cs_s3;
	// short or long frames are dropped whole
	assign frame_ok = frame_end && (bit_count == 6'(lpm_polling_pkg::FRAME_BITS));
	assign frame = rx_shift;
	// any other data is not the command, so it cannot put the part to sleep
	assign enter_cmd = frame_ok && frame.write && frame.addr == lpm_polling_pkg::ADDR_ENTER_SLEEP
		&& frame.data == lpm_polling_pkg::ENTER_SLEEP_DATA;

	always_comb
	begin
		next_answer = '0;
		next_answer.fault = fault_pending;
		next_answer.intflag = int_pending;
		next_answer.data = read_data;
		if (wake_report)
		begin
			next_answer.fault = 1'b1;
			next_answer.intflag = 1'b1;
			next_answer.data = sw_s2;
		end
	end

	// frame shifting: mosi taken on rising sclk, miso moved on falling sclk
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_shift <= 32'h00000000;
			tx_shift <= 32'h00000000;
			bit_count <= 6'h00;
			miso <= 1'b0;
		end
		else if (frame_start)
		begin
			bit_count <= 6'h00;
			tx_shift <= next_answer;
			miso <= next_answer[31];
		end
		else
		begin
			if (sclk_rise)
			begin
				rx_shift <= {rx_shift[30:0], mosi_s2};
				if (bit_count != 6'h3F)
					bit_count <= bit_count + 6'h01;
			end
			if (sclk_fall)
			begin
				tx_shift <= {tx_shift[30:0], 1'b0};
				miso <= tx_shift[30];
			end
		end
	end

	// registers: kept through sleep, only a valid write changes them
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slow_poll_ground_channels <= lpm_polling_pkg::SLOW_POLL_GROUND_RESET;
			debounce_programmable_channels <= lpm_polling_pkg::DEBOUNCE_PROG_RESET;
			debounce_ground_channels <= lpm_polling_pkg::DEBOUNCE_GROUND_RESET;
		end
		else if (frame_ok && frame.write)
		begin
			if (frame.addr == lpm_polling_pkg::ADDR_SLOW_POLL_GROUND)
				slow_poll_ground_channels <= frame.data[13:0];
			if (frame.addr == lpm_polling_pkg::ADDR_DEBOUNCE_PROG)
				debounce_programmable_channels <= frame.data[7:0];
			if (frame.addr == lpm_polling_pkg::ADDR_DEBOUNCE_GROUND)
				debounce_ground_channels <= frame.data[13:0];
		end
	end

	// read answer goes out in the next frame; sleep register reads as zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			read_data <= 22'h000000;
		else if (frame_ok && !frame.write)
		begin
			unique case (frame.addr)
				lpm_polling_pkg::ADDR_SLOW_POLL_GROUND: read_data <= {8'h00, slow_poll_ground_channels};
				lpm_polling_pkg::ADDR_DEBOUNCE_PROG: read_data <= {14'h0000, debounce_programmable_channels};
				lpm_polling_pkg::ADDR_DEBOUNCE_GROUND: read_data <= {8'h00, debounce_ground_channels};
				default: read_data <= 22'h000000;
			endcase
		end
	end

	// mode and wake report; a new wake beats the clear by frame start
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			low_power_mode <= 1'b0;
			wake_report <= 1'b0;
		end
		else
		begin
			if (enter_cmd)
				low_power_mode <= 1'b1;
			else if (low_power_mode && wake_s2)
				low_power_mode <= 1'b0;
			if (low_power_mode && wake_s2 && !enter_cmd)
				wake_report <= 1'b1;
			else if (frame_start)
				wake_report <= 1'b0;
		end
	end

	// per-channel polling; programmable channels have no slow bit here
	generate
		for (genvar i = 0; i < CH; i++)
		begin : g_chan
			logic [1:0] div;
			logic [EXT_W-1:0] ext;
			if (i < GC)
			begin : g_gnd
				assign slow_bit[i] = slow_poll_ground_channels[i];
				assign deb_bit[i] = debounce_ground_channels[i];
			end
			else
			begin : g_prog
				assign slow_bit[i] = 1'b0;
				assign deb_bit[i] = debounce_programmable_channels[i-GC];
			end
			assign poll_now[i] = low_power_mode && poll_tick && (!slow_bit[i] || div == 2'h0);

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					div <= 2'h0;
				else if (!low_power_mode || !slow_bit[i])
					div <= 2'h0;
				else if (poll_tick)
					div <= div + 2'h1;
			end

			// one tick of current, or stretched by the debounce time
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					poll_current_on[i] <= 1'b0;
					ext <= '0;
					sample_strobe[i] <= 1'b0;
					sample_by_level[i] <= 1'b0;
				end
				else
				begin
					sample_strobe[i] <= 1'b0;
					if (poll_now[i] && !poll_current_on[i])
					begin
						poll_current_on[i] <= 1'b1;
						ext <= deb_bit[i] ? EXT_LOAD : '0;
						sample_by_level[i] <= deb_bit[i];
					end
					else if (poll_current_on[i])
					begin
						if (ext == '0)
						begin
							poll_current_on[i] <= 1'b0;
							sample_strobe[i] <= 1'b1;
						end
						else
							ext <= ext - 1'b1;
					end
				end
			end
		end
	endgenerate

	property p_sleep_only_by_command;
		@(posedge clk) disable iff (!rst_b)
		$rose(low_power_mode) |-> $past(enter_cmd);
	endproperty
	a_sleep_only_by_command: assert property (p_sleep_only_by_command)
		else $error("sleep entered without the command");

	property p_slow_write;
		@(posedge clk) disable iff (!rst_b)
		frame_ok && frame.write && frame.addr == lpm_polling_pkg::ADDR_SLOW_POLL_GROUND
		|=> slow_poll_ground_channels == $past(frame.data[13:0]);
	endproperty
	a_slow_write: assert property (p_slow_write)
		else $error("ground slow-poll write not stored");

	property p_wake_flags;
		@(posedge clk) disable iff (!rst_b)
		frame_start && wake_report |=> tx_shift[23:22] == 2'b11 && tx_shift[21:0] == $past(sw_s2);
	endproperty
	a_wake_flags: assert property (p_wake_flags)
		else $error("wake frame lacks flags or pin states");

	property p_flags_live;
		@(posedge clk) disable iff (!rst_b)
		frame_start && !wake_report |=> tx_shift[23] == $past(fault_pending)
			&& tx_shift[22] == $past(int_pending);
	endproperty
	a_flags_live: assert property (p_flags_live)
		else $error("return flags not taken from pending status");

	property p_slow_quarter;
		@(posedge clk) disable iff (!rst_b)
		poll_now[1] && slow_bit[1] |=> g_chan[1].div == 2'h1 || !slow_bit[1] || !low_power_mode;
	endproperty
	a_slow_quarter: assert property (p_slow_quarter)
		else $error("slow channel poll divider off");

	property p_debounce_hold;
		@(posedge clk) disable iff (!rst_b)
		$rose(poll_current_on[0]) && sample_by_level[0] |-> poll_current_on[0] [*8];
	endproperty
	a_debounce_hold: assert property (p_debounce_hold)
		else $error("debounce current dropped early");

	property p_diff_single;
		@(posedge clk) disable iff (!rst_b)
		$rose(poll_current_on[1]) && !sample_by_level[1] |=> !poll_current_on[1] && sample_strobe[1];
	endproperty
	a_diff_single: assert property (p_diff_single)
		else $error("difference sampling not after one tick");

	property p_keep_in_sleep;
		@(posedge clk) disable iff (!rst_b)
		$fell(low_power_mode) |-> $stable(debounce_ground_channels) && $stable(slow_poll_ground_channels);
	endproperty
	a_keep_in_sleep: assert property (p_keep_in_sleep)
		else $error("configuration changed on wake");

	property p_upper_zero;
		@(posedge clk) disable iff (!rst_b)
		frame_start |=> tx_shift[31:24] == 8'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("unused answer bits not zero");

	property p_c_sleep;
		@(posedge clk) disable iff (!rst_b) enter_cmd;
	endproperty
	c_sleep: cover property (p_c_sleep);
	property p_c_wake;
		@(posedge clk) disable iff (!rst_b) frame_start && wake_report;
	endproperty
	c_wake: cover property (p_c_wake);
	property p_c_debounce;
		@(posedge clk) disable iff (!rst_b) sample_strobe[0] && sample_by_level[0];
	endproperty
	c_debounce: cover property (p_c_debounce);

endmodule : lpm_polling_config

// [lpm_host_model.sv]
// host side spi master: 32-bit mode 0 frames, msb first
// assumes the caller enters xfer on a core clock falling edge
`timescale 1ns/100ps
module lpm_host_model (
	// spi pins
	output logic sclk,
	output logic cs_b,
	output logic mosi,
	input wire logic miso
);
	initial
	begin
		sclk = 1'b0;
		cs_b = 1'b1;
		mosi = 1'b0;
	end
	// half period 40 ns; every step is a whole number of core cycles
	task automatic xfer(input lpm_polling_pkg::frame_type f, output lpm_polling_pkg::answer_type a);
		logic [31:0] w;
		w = f;
		cs_b = 1'b0;
		#80;
		for (int i = 31; i >= 0; i--)
		begin
			mosi = w[i];
			#40;
			sclk = 1'b1;
			a[i] = miso;
			#40;
			sclk = 1'b0;
		end
		#40;
		cs_b = 1'b1;
		// no stale bit left on a deselected line
		mosi = ~mosi;
		#80;
	endtask : xfer
endmodule : lpm_host_model

// [lpm_polling_config_bench.sv]
// self-checking bench of the low-power polling configuration block
// assumes lpm_host_model drives the spi pins
`timescale 1ns/100ps
module lpm_polling_config_bench;
	localparam int DEB = 16;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sclk, cs_b, mosi, miso;
	logic wake_request = 1'b0;
	logic [21:0] switch_state = 22'h2A5A5A;
	logic fault_pending = 1'b0;
	logic int_pending = 1'b0;
	logic poll_tick = 1'b0;
	logic low_power_mode;
	logic [21:0] poll_current_on, sample_strobe, sample_by_level, lvl;
	int err_total = 0;
	int n_tests = 0;
	int n_on [22];
	int n_st [22];
	logic [23:0] d;
	lpm_polling_pkg::answer_type ans;
	always #4 clk = ~clk;
	lpm_polling_config #(.DEBOUNCE_COUNT(DEB)) dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk),
		.cs_b(cs_b), .mosi(mosi), .miso(miso), .wake_request(wake_request),
		.switch_state(switch_state), .fault_pending(fault_pending), .int_pending(int_pending),
		.poll_tick(poll_tick), .low_power_mode(low_power_mode), .poll_current_on(poll_current_on),
		.sample_strobe(sample_strobe), .sample_by_level(sample_by_level));
	lpm_host_model host_u (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic frame(input logic [6:0] ad, input logic wr, input logic [23:0] dat);
		host_u.xfer('{addr: ad, write: wr, data: dat}, ans);
	endtask : frame
	// read data only comes back in the following frame
	task automatic rd(input logic [6:0] ad, output logic [23:0] dat);
		frame(ad, 1'b0, 24'h000000);
		frame(7'h00, 1'b0, 24'h000000);
		dat = ans[23:0];
	endtask : rd
	task automatic t_reset;
		for (int a = 25; a < 28; a++)
		begin
			rd(a[6:0], d);
			chk("reset value", d, 24'h000000);
		end
		chk("mode after reset", low_power_mode, 1'b0);
	endtask : t_reset
	task automatic t_rw;
		logic [23:0] m [3];
		m = '{24'h003FFF, 24'h0000FF, 24'h003FFF};
		for (int a = 0; a < 3; a++)
		begin
			frame(7'h19 + a[6:0], 1'b1, 24'hFFFFFF);
			rd(7'h19 + a[6:0], d);
			chk("masked readback", d, m[a]);
		end
		chk("mode after writes", low_power_mode, 1'b0);
		frame(7'h05, 1'b1, 24'hFFFFFF);
		rd(7'h05, d);
		chk("unmapped read", d, 24'h000000);
		rd(7'h1C, d);
		chk("sleep register read", d, 24'h000000);
		chk("mode after reads", low_power_mode, 1'b0);
		frame(7'h19, 1'b1, 24'h000002);
		frame(7'h1A, 1'b1, 24'h000001);
		frame(7'h1B, 1'b1, 24'h000001);
	endtask : t_rw
	task automatic t_flags;
		for (int k = 1; k < 4; k++)
		begin
			fault_pending = k[1];
			int_pending = k[0];
			rd(7'h19, d);
			chk("return flags", d, {k[1:0], 22'h000002});
		end
		fault_pending = 1'b0;
		int_pending = 1'b0;
	endtask : t_flags
	task automatic t_sleep;
		frame(7'h1C, 1'b1, 24'h000001);
		chk("nonzero sleep data", low_power_mode, 1'b0);
		frame(7'h1C, 1'b1, 24'h000000);
		chk("sleep command", low_power_mode, 1'b1);
	endtask : t_sleep
	task automatic tick_watch;
		foreach (n_on[c])
		begin
			n_on[c] = 0;
			n_st[c] = 0;
		end
		@(negedge clk);
		poll_tick = 1'b1;
		// first look is the cycle the current switches on
		repeat (DEB + 8)
		begin
			@(negedge clk);
			poll_tick = 1'b0;
			for (int c = 0; c < 22; c++)
			begin
				if (poll_current_on[c] === 1'b1)
					n_on[c]++;
				if (sample_strobe[c] === 1'b1)
				begin
					n_st[c]++;
					lvl[c] = sample_by_level[c];
				end
			end
		end
	endtask : tick_watch
	task automatic t_poll;
		tick_watch;
		chk("plain on cycles", n_on[2], 1);
		chk("plain strobe", {n_st[2], lvl[2]}, 2);
		chk("debounce on cycles", n_on[0], DEB);
		chk("debounce strobe", {n_st[0], lvl[0]}, 3);
		chk("prog debounce on", n_on[14], DEB);
		chk("slow first tick", n_st[1], 1);
		for (int k = 1; k < 5; k++)
		begin
			tick_watch;
			chk("slow later tick", n_st[1], k == 4);
			chk("neighbour each tick", n_st[2], 1);
		end
	endtask : t_poll
	task automatic t_wake;
		wake_request = 1'b1;
		repeat (6) @(negedge clk);
		chk("wake leaves sleep", low_power_mode, 1'b0);
		wake_request = 1'b0;
		frame(7'h1B, 1'b0, 24'h000000);
		chk("first frame after wake", ans[23:0], {2'b11, switch_state});
		frame(7'h00, 1'b0, 24'h000000);
		chk("kept ground debounce", ans[21:0], 22'h000001);
		rd(7'h19, d);
		chk("kept slow polling", d, 24'h000002);
	endtask : t_wake
	task automatic complete_run;
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_reset;
		t_rw;
		t_flags;
		t_sleep;
		t_poll;
		t_wake;
		complete_run;
	end
	// about 35 frames of under 3 us each
	initial
	begin
		#400000;
		err_total++;
		complete_run;
	end
endmodule : lpm_polling_config_bench
